// ==== rtl/eesc_top.sv ====
// Event enable mask with set/clear registers on an Avalon-MM slave
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module eesc_top
	import eesc_pkg::*;
(
	input  wire logic [EESC_ADDR_W-1:0]   avs_address_in,
	input  wire logic                     avs_read_in,
	input  wire logic                     avs_write_in,
	input  wire logic [EESC_DATA_W-1:0]   avs_writedata_in,
	input  wire logic [3:0]               avs_byteenable_in,
	output logic      [EESC_DATA_W-1:0]   avs_readdata_out,
	output logic                          avs_waitrequest_out,
	input  wire logic                     clk_sys_in,
	input  wire logic                     rstn_in,
	input  wire logic [EESC_EVENTS-1:0]   event_latch_in,
	input  wire logic [EESC_EVENTS-1:0]   chained_event_flags_in,
	input  wire logic [EESC_EVENTS-1:0]   manual_event_flags_in,
	output logic      [EESC_EVENTS-1:0]   event_mask_out,
	output logic      [EESC_EVENTS-1:0]   eval_request_out
);
	logic                   wait_q;
	logic [31:0]            rdata_q;
	logic [31:0]            rdata_d;
	logic [63:0]            eval_q;
	logic [63:0]            eval_d;
	logic                   req;
	logic                   acc_wr;
	logic                   acc_rd;
	logic [31:0]            lane_mask;
	logic [31:0]            wbits;
	logic                   hit_clr_lo;
	logic                   hit_clr_hi;
	logic                   hit_set_lo;
	logic                   hit_set_hi;
	logic                   hit_msk_lo;
	logic                   hit_msk_hi;
	logic [63:0]            mask_all;

	eesc_mask_if #(.W(EESC_HALF_W)) lo_if ();
	eesc_mask_if #(.W(EESC_HALF_W)) hi_if ();

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Request is accepted in the cycle waitrequest is low
	assign req        = avs_read_in | avs_write_in;
	assign acc_wr     = avs_write_in & ~wait_q;
	assign acc_rd     = avs_read_in & ~wait_q;
	assign hit_msk_lo = (avs_address_in == EESC_OFF_MASK_LOW);
	assign hit_msk_hi = (avs_address_in == EESC_OFF_MASK_HIGH);
	assign hit_clr_lo = (avs_address_in == EESC_OFF_CLR_LOW);
	assign hit_clr_hi = (avs_address_in == EESC_OFF_CLR_HIGH);
	assign hit_set_lo = (avs_address_in == EESC_OFF_SET_LOW);
	assign hit_set_hi = (avs_address_in == EESC_OFF_SET_HIGH);
	assign lane_mask  = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
			     {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign wbits      = avs_writedata_in & lane_mask;

	// no path from a mask-offset write into the mask
	assign lo_if.clr_bits = (acc_wr & hit_clr_lo) ? wbits : '0;
	assign hi_if.clr_bits = (acc_wr & hit_clr_hi) ? wbits : '0;
	assign lo_if.set_bits = (acc_wr & hit_set_lo) ? wbits : '0;
	assign hi_if.set_bits = (acc_wr & hit_set_hi) ? wbits : '0;

	// ----------------------------------------------------------------
	// Mask storage
	// ----------------------------------------------------------------
	eesc_mask_half #(.W(EESC_HALF_W)) u_lo (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.mb         (lo_if.half_port)
	);

	eesc_mask_half #(.W(EESC_HALF_W)) u_hi (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.mb         (hi_if.half_port)
	);

	assign mask_all = {hi_if.mask, lo_if.mask};

	// ----------------------------------------------------------------
	// Read data and event gating
	// ----------------------------------------------------------------
	// write-only and unmapped offsets read zero
	assign rdata_d = hit_msk_lo ? lo_if.mask :
			 hit_msk_hi ? hi_if.mask : EESC_READ_ZERO;
	// latched events pass only while enabled
	// chained and manual events bypass the mask
	assign eval_d  = (event_latch_in & mask_all) | chained_event_flags_in
			 | manual_event_flags_in;

	// One wait cycle per access keeps read data a clean flop
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(req & wait_q);
		end
	end

	// Read data captured while waitrequest is high
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_q <= EESC_READ_ZERO;
		end else if (avs_read_in & wait_q) begin
			rdata_q <= rdata_d;
		end
	end

	// no edge detect, so a pending event is evaluated once enabled
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			eval_q <= EESC_EVAL_RST;
		end else begin
			eval_q <= eval_d;
		end
	end

	// Mask flops are in the halves; output mirrors them directly
	assign avs_waitrequest_out = wait_q;
	assign avs_readdata_out    = rdata_q;
	assign eval_request_out    = eval_q;
	assign event_mask_out      = mask_all;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	property p_direct_ignored;
		(acc_wr & (hit_msk_lo | hit_msk_hi)) |=> (mask_all == $past(mask_all));
	endproperty
	a_direct_ignored: assert property (p_direct_ignored) else $error("Mask changed by direct write");

	property p_clr_low;
		(acc_wr & hit_clr_lo) |=> ((lo_if.mask & $past(wbits)) == '0);
	endproperty
	a_clr_low: assert property (p_clr_low) else $error("Low clear failed");

	property p_clr_high;
		(acc_wr & hit_clr_hi) |=> ((mask_all[63:32] & $past(wbits)) == '0);
	endproperty
	a_clr_high: assert property (p_clr_high) else $error("High clear failed");

	property p_set_low;
		(acc_wr & hit_set_lo) |=> ((event_mask_out[31:0] & $past(wbits)) == $past(wbits));
	endproperty
	a_set_low: assert property (p_set_low) else $error("Low set failed");

	property p_set_high;
		(acc_wr & hit_set_hi) |=> ((event_mask_out[63:32] & $past(wbits)) == $past(wbits));
	endproperty
	a_set_high: assert property (p_set_high) else $error("High set failed");

	property p_wo_reads_zero;
		(acc_rd & (hit_clr_lo | hit_clr_hi | hit_set_lo | hit_set_hi))
			|-> (avs_readdata_out == EESC_READ_ZERO);
	endproperty
	a_wo_reads_zero: assert property (p_wo_reads_zero) else $error("Write-only reg read nonzero");

	property p_gate_latch;
		##1 ((eval_request_out & ~$past(mask_all) & ~$past(chained_event_flags_in)
			& ~$past(manual_event_flags_in)) == '0);
	endproperty
	a_gate_latch: assert property (p_gate_latch) else $error("Disabled event evaluated");

	property p_pending_enabled;
		(|(event_latch_in & mask_all)) |=> (|eval_request_out);
	endproperty
	a_pending_enabled: assert property (p_pending_enabled) else $error("Enabled pending event lost");

	property p_bypass;
		##1 ((eval_request_out & $past(chained_event_flags_in | manual_event_flags_in))
			== $past(chained_event_flags_in | manual_event_flags_in));
	endproperty
	a_bypass: assert property (p_bypass) else $error("Chained or manual event blocked");

	property p_answer_bound;
		(req & wait_q) |=> !avs_waitrequest_out;
	endproperty
	a_answer_bound: assert property (p_answer_bound) else $error("Waitrequest held too long");

	c_set_write: cover property (acc_wr & hit_set_hi);
	c_clr_write: cover property (acc_wr & hit_clr_lo);
	c_mask_read: cover property (acc_rd & hit_msk_lo & (avs_readdata_out != '0));
	c_pending:   cover property ((event_latch_in[0] & ~mask_all[0]) ##1 (eval_request_out[0] == 1'b0)
				     ##[1:20] eval_request_out[0]);
endmodule
`default_nettype wire

// ==== rtl/eesc_pkg.sv ====
// Constants shared by the event enable set/clear register bank
package eesc_pkg;
	localparam int          EESC_DATA_W        = 32;
	localparam int          EESC_ADDR_W        = 8;
	localparam int          EESC_HALF_W        = 32;
	localparam int          EESC_EVENTS        = 64;
	// Byte offsets of the registers
	localparam logic [7:0]  EESC_OFF_MASK_LOW  = 8'h00;
	localparam logic [7:0]  EESC_OFF_MASK_HIGH = 8'h04;
	localparam logic [7:0]  EESC_OFF_CLR_LOW   = 8'h08;
	localparam logic [7:0]  EESC_OFF_CLR_HIGH  = 8'h0C;
	localparam logic [7:0]  EESC_OFF_SET_LOW   = 8'h10;
	localparam logic [7:0]  EESC_OFF_SET_HIGH  = 8'h14;
	// Reset and read values
	localparam logic [31:0] EESC_MASK_RST      = 32'h0000_0000;
	localparam logic [31:0] EESC_READ_ZERO     = 32'h0000_0000;
	localparam logic [63:0] EESC_EVAL_RST      = 64'h0000_0000_0000_0000;
endpackage

// ==== rtl/eesc_mask_if.sv ====
// Set/clear strobes and mask state between the top and one mask half
`timescale 1ns/10ps
`default_nettype none
interface eesc_mask_if #(
	parameter int W = 32
);
	logic [W-1:0] set_bits;
	logic [W-1:0] clr_bits;
	logic [W-1:0] mask;

	modport ctrl_port (output set_bits, output clr_bits, input mask);
	modport half_port (input set_bits, input clr_bits, output mask);
endinterface
`default_nettype wire

// ==== rtl/eesc_mask_half.sv ====
// One 32-event half of the enable mask with set/clear update
`timescale 1ns/10ps
`default_nettype none
module eesc_mask_half
	import eesc_pkg::*;
#(
	parameter int W = EESC_HALF_W
) (
	input  wire logic     clk_sys_in,
	input  wire logic     rstn_in,
	eesc_mask_if.half_port mb
);
	logic [W-1:0] mask_q;
	logic [W-1:0] mask_d;

	// ----------------------------------------------------------------
	// Mask update
	// ----------------------------------------------------------------
	// zeros leave bits alone
	assign mask_d = (mask_q | mb.set_bits) & ~mb.clr_bits;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_q <= W'(EESC_MASK_RST);
		end else begin
			mask_q <= mask_d;
		end
	end

	assign mb.mask = mask_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	property p_zero_keeps;
		##1 ((mask_q ^ $past(mask_q)) & ~($past(mb.set_bits) | $past(mb.clr_bits))) == '0;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("Unwritten mask bit changed");

	property p_set_sticks;
		(mb.set_bits != '0 && mb.clr_bits == '0) |=> ((mask_q & $past(mb.set_bits)) == $past(mb.set_bits));
	endproperty
	a_set_sticks: assert property (p_set_sticks) else $error("Set bit did not reach mask");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the event enable set/clear register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb
	import eesc_pkg::*;
;
	logic        clk_sys_in = 1'b0;
	logic        rstn_in    = 1'b0;
	logic        go         = 1'b0;
	logic [7:0]  address    = '0;
	logic        rd         = 1'b0;
	logic        wr         = 1'b0;
	logic [31:0] wdata      = '0;
	logic [3:0]  be         = '0;
	logic [31:0] rdata;
	logic        wreq;
	logic [63:0] latch      = '0;
	logic [63:0] chain      = '0;
	logic [63:0] manl       = '0;
	logic [63:0] mask;
	logic [63:0] evl;
	logic [63:0] model_q    = '0;
	logic [63:0] eval_exp   = '0;
	logic [31:0] seed       = 32'h0000_8f39;
	logic [31:0] exp_q[$];
	logic [31:0] exp_rd     = '0;
	logic [7:0]  tbl[8]     = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h00, 8'h04, 8'h11, 8'hFC};
	int          n_fail     = 0;
	int          cmp_count  = 0;
	logic [31:0] r;

	// ----------------------------------------
	// Clock and device under test
	// ----------------------------------------
	always #5 clk_sys_in = ~clk_sys_in;

	eesc_top uut (.avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq), .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.event_latch_in(latch), .chained_event_flags_in(chain),
		.manual_event_flags_in(manl), .event_mask_out(mask), .eval_request_out(evl));

	// Xorshift source, fixed seed
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// ----------------------------------------
	// Bus master: one access, model updated at acceptance edge
	// ----------------------------------------
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
			input logic [3:0] b);
		logic [31:0] ln;
		ln = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & d;
		@(posedge clk_sys_in);
		address <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		be <= b;
		if (!w) exp_q.push_back(a == EESC_OFF_MASK_LOW ? model_q[31:0] :
			a == EESC_OFF_MASK_HIGH ? model_q[63:32] : EESC_READ_ZERO);
		// No cycle count assumed; a hang is left to the watchdog
		do begin
			@(posedge clk_sys_in);
		end while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		// Mask changes only through set/clear offsets
		if (w) case (a)
			EESC_OFF_CLR_LOW:  model_q[31:0] <= model_q[31:0] & ~ln;
			EESC_OFF_CLR_HIGH: model_q[63:32] <= model_q[63:32] & ~ln;
			EESC_OFF_SET_LOW:  model_q[31:0] <= model_q[31:0] | ln;
			EESC_OFF_SET_HIGH: model_q[63:32] <= model_q[63:32] | ln;
			default: ;
		endcase
		#1;
		if (w) `CHK(mask, model_q)
	endtask

	// Random event traffic; chained/manual kept sparse so the mask shows
	always @(posedge clk_sys_in) begin
		if (go) begin
			latch <= {xs(), xs()};
			chain <= {xs(), xs()} & {xs(), xs()} & {xs(), xs()};
			manl <= {xs(), xs()} & {xs(), xs()} & {xs(), xs()};
		end
	end

	// ----------------------------------------
	// Monitor: read data against queue, evaluation every cycle
	// ----------------------------------------
	always @(posedge clk_sys_in) begin
		// Pop once; the check macro evaluates its arguments twice
		if (rd && wreq === 1'b0) begin
			exp_rd = exp_q.pop_front();
			`CHK(rdata, exp_rd)
		end
		if (rstn_in) `CHK(evl, eval_exp)
		eval_exp = rstn_in ? (latch & model_q) | chain | manl : EESC_EVAL_RST;
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		#50000;
		n_fail++;
		summarize();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		@(posedge clk_sys_in);
		`CHK(mask, EESC_EVAL_RST)
		for (int i = 0; i < 6; i++) bus(tbl[i], 1'b0, '0, 4'hF);
		$display("test reset done");
		go <= 1'b1;
		bus(EESC_OFF_SET_LOW, 1'b1, 32'hFFFF_FFFF, 4'hF);
		bus(EESC_OFF_SET_HIGH, 1'b1, 32'h8000_0001, 4'hF);
		bus(EESC_OFF_CLR_LOW, 1'b1, 32'h8000_0001, 4'hF);
		bus(EESC_OFF_CLR_HIGH, 1'b1, 32'h0000_0001, 4'hF);
		bus(EESC_OFF_MASK_LOW, 1'b1, 32'h0000_0000, 4'hF);
		bus(EESC_OFF_MASK_HIGH, 1'b1, 32'hFFFF_FFFF, 4'hF);
		for (int i = 0; i < 6; i++) bus(tbl[i], 1'b0, '0, 4'hF);
		$display("test directed done");
		for (int i = 0; i < 80; i++) begin
			r = xs();
			bus(tbl[r[2:0]], r[3], xs(), r[7:4]);
		end
		$display("test random done");
		summarize();
	end
endmodule
`default_nettype wire
